// *** logic/lfcd_top.v ***
`timescale 1ns/100ps
`include "lfcd_defs.vh"

// Function
// R1: alpha equals its mantissa times two to the power of minus 16, minus the shift, plus front and back gain.
// R2: the alpha mantissa spans 1 to 65535 and the alpha shift spans 0 to 63.
// R3: software puts alpha gain in the front gain up to 7 first and keeps the total gain at 22 or less.
// R4: beta and gamma are stored as positive magnitudes and applied as negative values.
// R5: beta magnitude is its 17-bit mantissa times two to the power of minus (17 plus its 5-bit exponent).
// R6: gamma magnitude is its 17-bit mantissa times two to the power of minus (17 plus its 5-bit exponent).
// R7: delta is its 15-bit mantissa times two to the power of minus (15 plus its 5-bit exponent).
module lfcd_top (
   input wire CLOCK,
   input wire RST_N,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [31:0] WB_ADR_I,
   input wire [31:0] WB_DAT_I,
   input wire [3:0] WB_SEL_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   output wire [`LFCD_W-1:0] ALPHA_SCALE,
   output wire [`LFCD_W-1:0] BETA_SCALE,
   output wire [`LFCD_W-1:0] GAMMA_SCALE,
   output wire [`LFCD_W-1:0] DELTA_SCALE,
   output reg SCALE_VALID
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function [31:0] wmerge;
      input [31:0] old;
      input [31:0] dat;
      input [3:0] sel;
      integer i;
      begin
         wmerge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               wmerge[i*8 +: 8] = dat[i*8 +: 8];
            end
         end
      end
   endfunction

   // lsb position of a mantissa weighted 2^-(base+exp) in the output word
   function [7:0] pos_of;
      input [7:0] base;
      input [4:0] exp;
      begin
         pos_of = `LFCD_FRAC - base - {3'h0, exp};
      end
   endfunction

   function [`LFCD_MW-1:0] mant_clamp;
      input [`LFCD_MW-1:0] m;
      begin
         mant_clamp = (m == {`LFCD_MW{1'b0}}) ? `LFCD_MANT_MIN : m;
      end
   endfunction

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   reg [31:0] alpha_mant;
   reg [31:0] alpha_exp;
   reg [31:0] beta_reg;
   reg [31:0] gamma_reg;
   reg [31:0] delta_reg;
   reg auto_apply;
   reg pending;
   reg load;
   reg load_d;
   reg [`LFCD_AM_MSB:0] act_am;
   reg [`LFCD_ASH_MSB:0] act_ash;
   reg [`LFCD_AFG_MSB-`LFCD_AFG_LSB:0] act_afg;
   reg [`LFCD_ABG_MSB-`LFCD_ABG_LSB:0] act_abg;
   reg [`LFCD_BG_MSB:0] act_bm;
   reg [`LFCD_BG_MSB:0] act_gm;
   reg [`LFCD_DM_MSB:0] act_dm;
   reg [4:0] act_be;
   reg [4:0] act_ge;
   reg [4:0] act_de;
   reg [31:0] next_dat;

   wire req;
   wire wr;
   wire [2:0] idx;
   wire coef_wr;
   wire apply_wr;
   wire gain_over;
   wire [4:0] gain_sum;

   // full words so the reset branch can slice each field width from a constant
   localparam [31:0] rst_mant = `LFCD_RST_MANT;
   localparam [31:0] rst_exp = `LFCD_RST_EXP;

   // one access per request; ack gap keeps a held request from repeating
   assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   // unmapped addresses are acked but never written
   assign wr = req & WB_WE_I & (WB_ADR_I[31:5] == 27'h0000000);
   assign idx = WB_ADR_I[4:2];
   assign coef_wr = wr & (idx <= `LFCD_ADR_DELTA) & (WB_ADR_I[31:5] == 27'h0000000);
   assign apply_wr = wr & (idx == `LFCD_ADR_CTRL) & (WB_ADR_I[31:5] == 27'h0000000) &
      WB_SEL_I[0] & WB_DAT_I[`LFCD_CTRL_APPLY];
   assign gain_sum = {2'h0, act_afg} + {1'b0, act_abg};
   assign gain_over = gain_sum > `LFCD_GAIN_MAX; // R3

   always @* begin
      next_dat = 32'h00000000;
      if (WB_ADR_I[31:5] == 27'h0000000) begin
         case (idx)
            `LFCD_ADR_ALPHA_MANT: next_dat = alpha_mant;
            `LFCD_ADR_ALPHA_EXP: next_dat = alpha_exp;
            `LFCD_ADR_BETA: next_dat = beta_reg;
            `LFCD_ADR_GAMMA: next_dat = gamma_reg;
            `LFCD_ADR_DELTA: next_dat = delta_reg;
            `LFCD_ADR_CTRL: next_dat = {30'h00000000, auto_apply, 1'b0};
            `LFCD_ADR_STATUS: next_dat = {30'h00000000, gain_over, pending};
            default: next_dat = 32'h00000000;
         endcase
      end
   end

   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
         alpha_mant <= `LFCD_RST_MANT;
         alpha_exp <= `LFCD_RST_EXP;
         beta_reg <= `LFCD_RST_MANT;
         gamma_reg <= `LFCD_RST_MANT;
         delta_reg <= `LFCD_RST_MANT;
         auto_apply <= 1'b0;
         pending <= 1'b0;
         load <= 1'b0;
      end else begin
         WB_ACK_O <= req;
         WB_DAT_O <= req ? next_dat : 32'h00000000;
         load <= apply_wr | (coef_wr & auto_apply);
         // unused field bits are masked so they read back as zero
         if (wr && idx == `LFCD_ADR_ALPHA_MANT) begin
            alpha_mant <= wmerge(alpha_mant, WB_DAT_I, WB_SEL_I) & 32'h0000FFFF; // R2
         end
         if (wr && idx == `LFCD_ADR_ALPHA_EXP) begin
            alpha_exp <= wmerge(alpha_exp, WB_DAT_I, WB_SEL_I) & 32'h000F073F; // R2
         end
         if (wr && idx == `LFCD_ADR_BETA) begin
            beta_reg <= wmerge(beta_reg, WB_DAT_I, WB_SEL_I) & 32'h1F01FFFF; // R5
         end
         if (wr && idx == `LFCD_ADR_GAMMA) begin
            gamma_reg <= wmerge(gamma_reg, WB_DAT_I, WB_SEL_I) & 32'h1F01FFFF; // R6
         end
         if (wr && idx == `LFCD_ADR_DELTA) begin
            delta_reg <= wmerge(delta_reg, WB_DAT_I, WB_SEL_I) & 32'h1F007FFF; // R7
         end
         if (wr && idx == `LFCD_ADR_CTRL && WB_SEL_I[0]) begin
            auto_apply <= WB_DAT_I[`LFCD_CTRL_AUTO];
         end
         // a fresh coefficient write outranks a concurrent apply
         if (coef_wr && !auto_apply) begin
            pending <= 1'b1;
         end else if (apply_wr || coef_wr) begin
            pending <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // active coefficient set
   // ----------------------------------------------------------------
   // shadowed so that, with auto apply off, the filter core never sees a half-written profile
   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         act_am <= rst_mant[`LFCD_AM_MSB:0];
         act_ash <= rst_exp[`LFCD_ASH_MSB:0];
         act_afg <= rst_exp[`LFCD_AFG_MSB-`LFCD_AFG_LSB:0];
         act_abg <= rst_exp[`LFCD_ABG_MSB-`LFCD_ABG_LSB:0];
         act_bm <= rst_mant[`LFCD_BG_MSB:0];
         act_gm <= rst_mant[`LFCD_BG_MSB:0];
         act_dm <= rst_mant[`LFCD_DM_MSB:0];
         act_be <= rst_exp[`LFCD_EXP_MSB-`LFCD_EXP_LSB:0];
         act_ge <= rst_exp[`LFCD_EXP_MSB-`LFCD_EXP_LSB:0];
         act_de <= rst_exp[`LFCD_EXP_MSB-`LFCD_EXP_LSB:0];
         SCALE_VALID <= 1'b0;
      end else begin
         if (load) begin
            act_am <= alpha_mant[`LFCD_AM_MSB:0];
            act_ash <= alpha_exp[`LFCD_ASH_MSB:0];
            act_afg <= alpha_exp[`LFCD_AFG_MSB:`LFCD_AFG_LSB];
            act_abg <= alpha_exp[`LFCD_ABG_MSB:`LFCD_ABG_LSB];
            act_bm <= beta_reg[`LFCD_BG_MSB:0];
            act_gm <= gamma_reg[`LFCD_BG_MSB:0];
            act_dm <= delta_reg[`LFCD_DM_MSB:0];
            act_be <= beta_reg[`LFCD_EXP_MSB:`LFCD_EXP_LSB];
            act_ge <= gamma_reg[`LFCD_EXP_MSB:`LFCD_EXP_LSB];
            act_de <= delta_reg[`LFCD_EXP_MSB:`LFCD_EXP_LSB];
         end
         SCALE_VALID <= load_d;
      end
   end

   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         load_d <= 1'b0;
      end else begin
         load_d <= load;
      end
   end

   // ----------------------------------------------------------------
   // scale factors
   // ----------------------------------------------------------------
   wire [4*`LFCD_MW-1:0] mant_bus;
   wire [31:0] pos_bus;
   wire [3:0] neg_bus;
   wire [4*`LFCD_W-1:0] scale_bus;
   wire [7:0] alpha_pos;

   // alpha: lsb at 2^(-16 - shift + front + back)
   assign alpha_pos = `LFCD_FRAC - `LFCD_ALPHA_BASE - {2'h0, act_ash} + {5'h00, act_afg} + {4'h0, act_abg}; // R1
   assign mant_bus = {mant_clamp({2'h0, act_dm}), mant_clamp(act_gm), mant_clamp(act_bm),
      mant_clamp({1'b0, act_am})}; // R2
   assign pos_bus = {pos_of(`LFCD_DELTA_BASE, act_de), pos_of(`LFCD_GAMMA_BASE, act_ge),
      pos_of(`LFCD_BETA_BASE, act_be), alpha_pos}; // R5 R6 R7
   assign neg_bus = 4'h6; // R4

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_scale
         lfcd_scale u_scale (
            .clk(CLOCK),
            .rst_n(RST_N),
            .mant(mant_bus[g*`LFCD_MW +: `LFCD_MW]),
            .pos(pos_bus[g*8 +: 8]),
            .neg(neg_bus[g]),
            .scale(scale_bus[g*`LFCD_W +: `LFCD_W])
         );
      end
   endgenerate

   assign ALPHA_SCALE = scale_bus[0 +: `LFCD_W];
   assign BETA_SCALE = scale_bus[`LFCD_W +: `LFCD_W];
   assign GAMMA_SCALE = scale_bus[2*`LFCD_W +: `LFCD_W];
   assign DELTA_SCALE = scale_bus[3*`LFCD_W +: `LFCD_W];
endmodule // lfcd_top

// *** logic/lfcd_defs.vh ***
`ifndef LFCD_DEFS_VH
`define LFCD_DEFS_VH

// ----------------------------------------------------------------
// scale factor format
// ----------------------------------------------------------------
// signed two's complement, lsb weighs 2^-48
`define LFCD_W 80
`define LFCD_MW 17
`define LFCD_FRAC 8'h30

// ----------------------------------------------------------------
// exponent bases and limits
// ----------------------------------------------------------------
`define LFCD_ALPHA_BASE 8'h10
`define LFCD_BETA_BASE 8'h11
`define LFCD_GAMMA_BASE 8'h11
`define LFCD_DELTA_BASE 8'h0F
`define LFCD_GAIN_MAX 5'h16
`define LFCD_MANT_MIN 17'h00001

// ----------------------------------------------------------------
// register word offsets (address bits [4:2] decoded)
// ----------------------------------------------------------------
`define LFCD_ADR_ALPHA_MANT 3'h0
`define LFCD_ADR_ALPHA_EXP 3'h1
`define LFCD_ADR_BETA 3'h2
`define LFCD_ADR_GAMMA 3'h3
`define LFCD_ADR_DELTA 3'h4
`define LFCD_ADR_CTRL 3'h5
`define LFCD_ADR_STATUS 3'h6

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LFCD_AM_MSB 15
`define LFCD_ASH_MSB 5
`define LFCD_AFG_LSB 8
`define LFCD_AFG_MSB 10
`define LFCD_ABG_LSB 16
`define LFCD_ABG_MSB 19
`define LFCD_BG_MSB 16
`define LFCD_DM_MSB 14
`define LFCD_EXP_LSB 24
`define LFCD_EXP_MSB 28
`define LFCD_CTRL_APPLY 0
`define LFCD_CTRL_AUTO 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LFCD_RST_MANT 32'h00000001
`define LFCD_RST_EXP 32'h00000000

`endif

// *** logic/lfcd_scale.v ***
`timescale 1ns/100ps
`include "lfcd_defs.vh"

// ----------------------------------------------------------------
// mantissa times power of two, optional negation, registered
// ----------------------------------------------------------------
module lfcd_scale (
   input wire clk,
   input wire rst_n,
   input wire [`LFCD_MW-1:0] mant,
   input wire [7:0] pos,
   input wire neg,
   output reg [`LFCD_W-1:0] scale
);
   wire [7:0] rsh;
   wire [`LFCD_W-1:0] ext;
   wire [`LFCD_W-1:0] mag;
   wire [`LFCD_W-1:0] next_scale;

   // pos is signed: bit position of the mantissa lsb in the output word
   assign rsh = (~pos) + 8'h01;
   assign ext = {{(`LFCD_W-`LFCD_MW){1'b0}}, mant};
   // weights below 2^-48 are truncated, a limitation of the fixed format
   assign mag = pos[7] ? (ext >> rsh) : (ext << pos);
   assign next_scale = neg ? ((~mag) + {{(`LFCD_W-1){1'b0}}, 1'b1}) : mag;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scale <= {`LFCD_W{1'b0}};
      end else begin
         scale <= next_scale;
      end
   end
endmodule // lfcd_scale

// *** test/lfcd_top_assertions.sv ***
`timescale 1ns/100ps
`include "lfcd_defs.vh"
module lfcd_checker (
   input wire CLOCK,
   input wire RST_N,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [31:0] WB_ADR_I,
   input wire [31:0] WB_DAT_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_O,
   input wire WB_ACK_O,
   input wire [`LFCD_W-1:0] ALPHA_SCALE,
   input wire [`LFCD_W-1:0] BETA_SCALE,
   input wire [`LFCD_W-1:0] GAMMA_SCALE,
   input wire [`LFCD_W-1:0] DELTA_SCALE,
   input wire SCALE_VALID
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   // ----------------------------------------------------------------
   // access steps
   // ----------------------------------------------------------------
   sequence s_take;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence s_apply;
      s_take ##0 (WB_WE_I && WB_ADR_I == 32'h00000014 && WB_SEL_I[0] && WB_DAT_I[0]);
   endsequence
   a_ack_next: assert property (s_take |=> WB_ACK_O) else $error("no ack after request");
   a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
   a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("read data without ack");
   a_unmapped_zero: assert property (s_take ##0 (!WB_WE_I && WB_ADR_I[4:2] == 3'h7) |=> WB_DAT_O == 32'h0)
      else $error("unmapped read not zero");
   // apply path has three register stages, allow for output sampling
   a_apply_valid: assert property (s_apply |-> ##[3:4] SCALE_VALID) else $error("apply gave no valid");
   a_valid_pulse: assert property (SCALE_VALID |=> !SCALE_VALID) else $error("valid held too long");
   a_alpha_range: assert property (SCALE_VALID |-> ALPHA_SCALE[79:70] == 10'h0) else $error("alpha range");
   a_beta_negative: assert property (SCALE_VALID |-> BETA_SCALE[79:48] == 32'hFFFFFFFF) else $error("beta");
   a_gamma_negative: assert property (SCALE_VALID |-> &GAMMA_SCALE[79:48]) else $error("gamma sign");
   a_delta_range: assert property (SCALE_VALID |-> DELTA_SCALE[79:48] == 32'h0 && DELTA_SCALE != 80'h0)
      else $error("delta range");
endmodule // lfcd_checker
bind lfcd_top lfcd_checker u_lfcd_checker (.CLOCK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_I,
   .WB_SEL_I, .WB_DAT_O, .WB_ACK_O, .ALPHA_SCALE, .BETA_SCALE, .GAMMA_SCALE, .DELTA_SCALE, .SCALE_VALID);

// *** test/lfcd_top_bench.sv ***
`timescale 1ns/100ps
`include "lfcd_defs.vh"
module lfcd_top_bench;
   reg CLOCK = 1'b0;
   reg RST_N = 1'b0;
   reg cyc = 1'b0;
   reg we = 1'b0;
   reg [31:0] adr = 32'h0;
   reg [31:0] dat = 32'h0;
   reg [3:0] sel = 4'h0;
   reg [3:0] wsel = 4'hF;
   wire [31:0] dat_o;
   wire ack;
   wire valid;
   wire [`LFCD_W-1:0] a_s, b_s, g_s, d_s;
   integer failures = 0;
   integer n_checks = 0;
   reg [31:0] rdat;
   always #5 CLOCK = ~CLOCK;
   lfcd_top u_lfcd_top (.CLOCK(CLOCK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(sel), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .ALPHA_SCALE(a_s),
      .BETA_SCALE(b_s), .GAMMA_SCALE(g_s), .DELTA_SCALE(d_s), .SCALE_VALID(valid));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task check(input [79:0] seen, input [79:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", n_checks, failures);
         if (failures == 0 && n_checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   // classic cycle: hold request until ack is sampled, then release
   task wb(input w, input [31:0] a, input [31:0] d);
      integer i;
      begin
         @(posedge CLOCK);
         cyc <= 1'b1;
         we <= w;
         adr <= a;
         dat <= d;
         sel <= wsel;
         for (i = 0; i < 20 && ack !== 1'b1; i = i + 1)
            @(posedge CLOCK);
         rdat = dat_o;
         cyc <= 1'b0;
         if (ack !== 1'b1) begin
            failures = failures + 1;
            complete_run;
         end
      end
   endtask
   task rd(input [31:0] a, input [31:0] exp);
      begin
         wb(1'b0, a, 32'h0);
         check({48'h0, rdat}, {48'h0, exp});
      end
   endtask
   // the trigger is an apply write, or a coefficient write while auto apply is on
   task apply_chk(input [31:0] ta, input [31:0] td, input [79:0] ea, input [79:0] eb, input [79:0] eg,
      input [79:0] ed);
      integer i;
      begin
         wb(1'b1, ta, td);
         for (i = 0; i < 10 && valid !== 1'b1; i = i + 1)
            @(posedge CLOCK);
         if (valid !== 1'b1) begin
            failures = failures + 1;
            complete_run;
         end
         check(a_s, ea);
         check(b_s, eb);
         check(g_s, eg);
         check(d_s, ed);
      end
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge CLOCK);
      RST_N <= 1'b1;
      repeat (3) @(posedge CLOCK);
      check(a_s, 80'h1 << 32);
      check(b_s, -(80'h1 << 31));
      check(g_s, -(80'h1 << 31));
      check(d_s, 80'h1 << 33);
      check({79'h0, valid}, 80'h0);
      rd(32'h00, 32'h00000001);
      rd(32'h04, 32'h00000000);
      rd(32'h1C, 32'h00000000);
      $display("reset test done");
      wb(1'b1, 32'h00, 32'h0000D0A8);
      wb(1'b1, 32'h04, 32'h00000006);
      wb(1'b1, 32'h08, 32'h0D01250B);
      wb(1'b1, 32'h0C, 32'h0D013ABB);
      wb(1'b1, 32'h10, 32'h0800420A);
      rd(32'h18, 32'h00000001);
      apply_chk(32'h14, 32'h1, 80'h0D0A8 << 26, -(80'h1250B << 18), -(80'h13ABB << 18),
         80'h420A << 25);
      rd(32'h18, 32'h00000000);
      $display("example test done");
      // full gain: front 7 then back 15, total 22
      wb(1'b1, 32'h00, 32'h0000FFFF);
      wb(1'b1, 32'h04, 32'h000F0700);
      apply_chk(32'h14, 32'h1, 80'hFFFF << 54, -(80'h1250B << 18), -(80'h13ABB << 18),
         80'h420A << 25);
      rd(32'h18, 32'h00000000);
      $display("gain test done");
      wb(1'b1, 32'h04, 32'h0000003F);
      wb(1'b1, 32'h08, 32'h1F01FFFF);
      wb(1'b1, 32'h0C, 32'h00000000);
      wb(1'b1, 32'h10, 32'h1F007FFF);
      apply_chk(32'h14, 32'h1, 80'h0, -(80'h1FFFF), -(80'h1 << 31), 80'h7FFF << 2);
      $display("limit test done");
      // byte lane write: only the low byte of the alpha mantissa changes
      wsel = 4'h1;
      wb(1'b1, 32'h00, 32'h0000ABCD);
      wsel = 4'hF;
      rd(32'h00, 32'h0000FFCD);
      // auto apply: a coefficient write alone loads the active set
      wb(1'b1, 32'h14, 32'h2);
      rd(32'h14, 32'h00000002);
      apply_chk(32'h10, 32'h0800420A, 80'h0, -(80'h1FFFF), -(80'h1 << 31), 80'h420A << 25);
      rd(32'h18, 32'h00000000);
      $display("auto test done");
      complete_run;
   end
endmodule // lfcd_top_bench
